/* File: srxef_top.sv */
// Serial port with receive error flags, reached over AXI4-Lite.
// Assumes rxd is already synchronous to aclk; one clock domain.
//
// Notes on behaviour
// - A reception ending while receive-full is set raises overrun.
// - On overrun the held receive data word is kept, not overwritten.
// - On overrun the newly received character is thrown away.
// - No new reception starts while the overrun flag is set.
// - In synchronous mode overrun also stops transmission until cleared.
// - Overrun clears only by reading it as one, then writing zero.
// - Dropping receive enable leaves the overrun flag as it was.
// - A zero first stop bit in asynchronous mode raises the framing flag if receive-full is clear.
// - With two stop bits only the first one is checked.
// - A framing error still loads the data word but not receive-full.
// - No new reception starts while the framing flag is set.
// - In clocked synchronous mode a framing flag also stops transmission.
// - Framing flag clears only by reading it as one, then writing zero.
// - Dropping receive enable leaves the framing flag as it was.
// - Writing one to an error flag has no effect; only zero clears.
// - Receive-full sets only when a reception ends normally and loads data.
//
// Decided for this implementation: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
module srxef_top
  import srxef_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  // AXI4-Lite write data
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // AXI4-Lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read address
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  // AXI4-Lite read data
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Serial line
  input wire logic rxd,
  output logic txd,
  output logic sck_out,
  // Receive error interrupt request
  output logic rx_err_irq
);

  function automatic logic addr_mapped(input logic [7:0] a);
    return (a == ADDR_CTRL) || (a == ADDR_DIV) || (a == ADDR_STAT) ||
           (a == ADDR_RXDATA) || (a == ADDR_TXDATA);
  endfunction : addr_mapped

  logic [7:0] ctrl;
  logic [15:0] div;
  logic [NUM_FLAGS-1:0] flags;
  logic [NUM_FLAGS-1:0] armed;
  logic [NUM_FLAGS-1:0] flag_set;
  logic [NUM_FLAGS-1:0] flag_clr;
  logic [CHAR_W-1:0] rx_data_reg;

  logic rx_enable;
  logic tx_enable;
  logic sync_mode;
  logic two_stop;
  logic overrun_flag;
  logic framing_flag;
  logic rx_full_flag;
  logic any_error;

  assign rx_enable = ctrl[CTRL_RX_ENABLE];
  assign tx_enable = ctrl[CTRL_TX_ENABLE];
  assign sync_mode = ctrl[CTRL_SYNC_MODE];
  assign two_stop = ctrl[CTRL_TWO_STOP];
  assign overrun_flag = flags[FLAG_OVERRUN];
  assign framing_flag = flags[FLAG_FRAMING];
  assign rx_full_flag = flags[FLAG_RX_FULL];
  assign any_error = overrun_flag || framing_flag;

  // Write channel capture; address and data may come in either order
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic wr_go;
  logic wr_stall;
  logic stat_wr;
  logic stat_rd;
  logic fifo_in_valid;
  logic fifo_in_ready;

  // A full transmit buffer holds the write back rather than drop data
  assign wr_stall = (aw_addr_q == ADDR_TXDATA) && w_strb_q[0] &&
                    !fifo_in_ready;
  assign wr_go = aw_held && w_held && !bvalid && !wr_stall;
  assign fifo_in_valid = wr_go && (aw_addr_q == ADDR_TXDATA) && w_strb_q[0];
  assign stat_wr = wr_go && (aw_addr_q == ADDR_STAT) && w_strb_q[0];
  assign stat_rd = arvalid && arready && (araddr == ADDR_STAT);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      awready <= 1'b0;
      aw_addr_q <= 8'h00;
    end else if (awvalid && awready) begin
      aw_held <= 1'b1;
      awready <= 1'b0;
      aw_addr_q <= awaddr;
    end else if (wr_go) begin
      aw_held <= 1'b0;
      awready <= 1'b0;
    end else begin
      awready <= !aw_held && !bvalid;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      wready <= 1'b0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
    end else if (wvalid && wready) begin
      w_held <= 1'b1;
      wready <= 1'b0;
      w_data_q <= wdata;
      w_strb_q <= wstrb;
    end else if (wr_go) begin
      w_held <= 1'b0;
      wready <= 1'b0;
    end else begin
      wready <= !w_held && !bvalid;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else if (wr_go) begin
      bvalid <= 1'b1;
      bresp <= addr_mapped(aw_addr_q) ? RESP_OKAY : RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // Control and divisor; rx_enable has no path to clear the flags
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= CTRL_RESET;
      div <= DIV_RESET;
    end else if (wr_go) begin
      if (aw_addr_q == ADDR_CTRL && w_strb_q[0]) begin
        ctrl <= w_data_q[7:0];
      end
      if (aw_addr_q == ADDR_DIV) begin
        if (w_strb_q[0]) begin
          div[7:0] <= w_data_q[7:0];
        end
        if (w_strb_q[1]) begin
          div[15:8] <= w_data_q[15:8];
        end
      end
    end
  end

  // Read channel
  logic fifo_out_valid;
  logic [31:0] rd_word;

  always_comb begin
    rd_word = 32'h0000_0000;
    unique case (araddr)
      ADDR_CTRL: rd_word[7:0] = ctrl;
      ADDR_DIV: rd_word[15:0] = div;
      ADDR_STAT: begin
        rd_word[STAT_FLAG_LSB +: NUM_FLAGS] = flags;
        rd_word[STAT_TX_SPACE] = fifo_in_ready;
      end
      ADDR_RXDATA: rd_word[CHAR_W-1:0] = rx_data_reg;
      default: rd_word = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= rd_word;
      rresp <= addr_mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end else begin
      arready <= !rvalid;
    end
  end

  // Receive completion events from the two engines
  logic done_async;
  logic bad_stop_async;
  logic done_sync;
  logic [CHAR_W-1:0] shift_async;
  logic [CHAR_W-1:0] shift_sync;
  logic rx_done;
  logic rx_bad_stop;
  logic [CHAR_W-1:0] rx_word;
  logic rx_load;

  assign rx_done = done_async || done_sync;
  assign rx_bad_stop = done_async && bad_stop_async;
  assign rx_word = done_async ? shift_async : shift_sync;
  assign rx_load = rx_done && !rx_full_flag;
  assign flag_set[FLAG_OVERRUN] = rx_done && rx_full_flag;
  assign flag_set[FLAG_FRAMING] = rx_load && rx_bad_stop;
  assign flag_set[FLAG_RX_FULL] = rx_load && !rx_bad_stop;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_data_reg <= 8'h00;
    end else if (rx_load) begin
      rx_data_reg <= rx_word;
    end
  end

  // Each flag: armed by a read showing one, cleared by a later zero write
  generate
    for (genvar i = 0; i < NUM_FLAGS; i++) begin : g_flag
      assign flag_clr[i] = stat_wr && armed[i] &&
                           !w_data_q[STAT_FLAG_LSB + i];
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          flags[i] <= FLAGS_RESET[i];
        end else if (flag_set[i]) begin
          flags[i] <= 1'b1;
        end else if (flag_clr[i]) begin
          flags[i] <= 1'b0;
        end
      end
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          armed[i] <= 1'b0;
        end else if (stat_rd) begin
          armed[i] <= flags[i];
        end else if (stat_wr) begin
          armed[i] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_err_irq <= 1'b0;
    end else begin
      rx_err_irq <= ctrl[CTRL_RX_IRQ_EN] && any_error;
    end
  end

  // Asynchronous receiver
  srxef_rx_state_t rx_state;
  logic [15:0] rx_cnt;
  logic [2:0] rx_bit;
  logic [15:0] half_div;

  assign half_div = {1'b0, div[15:1]};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_state <= RX_IDLE;
      rx_cnt <= 16'h0000;
      rx_bit <= 3'h0;
      shift_async <= 8'h00;
      done_async <= 1'b0;
      bad_stop_async <= 1'b0;
    end else begin
      done_async <= 1'b0;
      if (!rx_enable || sync_mode) begin
        rx_state <= RX_IDLE;
      end else begin
        unique case (rx_state)
          RX_IDLE: begin
            if (!any_error && !rxd) begin
              rx_cnt <= half_div;
              rx_state <= RX_START;
            end
          end
          RX_START: begin
            if (rx_cnt == 16'h0000) begin
              rx_cnt <= div - 16'h0001;
              rx_bit <= 3'h0;
              rx_state <= rxd ? RX_IDLE : RX_DATA;
            end else begin
              rx_cnt <= rx_cnt - 16'h0001;
            end
          end
          RX_DATA: begin
            if (rx_cnt == 16'h0000) begin
              shift_async <= {rxd, shift_async[CHAR_W-1:1]};
              rx_cnt <= div - 16'h0001;
              rx_bit <= rx_bit + 3'h1;
              if (rx_bit == LAST_BIT) begin
                rx_state <= RX_STOP1;
              end
            end else begin
              rx_cnt <= rx_cnt - 16'h0001;
            end
          end
          RX_STOP1: begin
            if (rx_cnt == 16'h0000) begin
              done_async <= 1'b1;
              bad_stop_async <= !rxd;
              rx_cnt <= div - 16'h0001;
              rx_state <= two_stop ? RX_STOP2 : RX_IDLE;
            end else begin
              rx_cnt <= rx_cnt - 16'h0001;
            end
          end
          RX_STOP2: begin
            // Second stop bit is waited out but never judged
            if (rx_cnt == 16'h0000) begin
              rx_state <= RX_IDLE;
            end else begin
              rx_cnt <= rx_cnt - 16'h0001;
            end
          end
          default: rx_state <= RX_IDLE;
        endcase
      end
    end
  end

  // Transmit buffer
  logic [CHAR_W-1:0] fifo_out_data;
  logic fifo_out_ready;
  logic tx_start_ok;

  srxef_fifo #(
    .WIDTH(CHAR_W),
    .DEPTH(TX_FIFO_DEPTH)
  ) u_tx_fifo (
    .aclk(aclk),
    .aresetn(aresetn),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(w_data_q[CHAR_W-1:0]),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  // Transmitter; in synchronous mode it also clocks the receive side
  srxef_tx_state_t tx_state;
  logic [15:0] tx_cnt;
  logic [2:0] tx_bit;
  logic [CHAR_W-1:0] tx_shift;
  logic tx_extra_stop;

  // An overrun raised this very cycle must hold off the next frame too
  assign tx_start_ok = tx_enable && fifo_out_valid &&
                       !(sync_mode && (any_error ||
                       flag_set[FLAG_OVERRUN]));
  assign fifo_out_ready = (tx_state == TX_IDLE) && tx_start_ok;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_state <= TX_IDLE;
      tx_cnt <= 16'h0000;
      tx_bit <= 3'h0;
      tx_shift <= 8'h00;
      tx_extra_stop <= 1'b0;
      txd <= 1'b1;
      sck_out <= 1'b1;
      shift_sync <= 8'h00;
      done_sync <= 1'b0;
    end else begin
      done_sync <= 1'b0;
      unique case (tx_state)
        TX_IDLE: begin
          if (fifo_out_ready) begin
            tx_shift <= fifo_out_data;
            tx_cnt <= div - 16'h0001;
            tx_bit <= 3'h0;
            tx_state <= sync_mode ? TX_DATA : TX_START;
            txd <= sync_mode ? fifo_out_data[0] : 1'b0;
            sck_out <= !sync_mode;
          end
        end
        TX_START: begin
          if (tx_cnt == 16'h0000) begin
            tx_cnt <= div - 16'h0001;
            txd <= tx_shift[0];
            tx_state <= TX_DATA;
          end else begin
            tx_cnt <= tx_cnt - 16'h0001;
          end
        end
        TX_DATA: begin
          if (sync_mode && tx_cnt == half_div) begin
            sck_out <= 1'b1;
            shift_sync <= {rxd, shift_sync[CHAR_W-1:1]};
          end
          if (tx_cnt == 16'h0000) begin
            tx_cnt <= div - 16'h0001;
            tx_bit <= tx_bit + 3'h1;
            tx_shift <= {1'b1, tx_shift[CHAR_W-1:1]};
            if (tx_bit == LAST_BIT) begin
              txd <= 1'b1;
              tx_extra_stop <= two_stop;
              // Synchronous frames have no stop bit; reception ends here
              tx_state <= sync_mode ? TX_IDLE : TX_STOP;
              done_sync <= sync_mode && rx_enable;
            end else begin
              txd <= tx_shift[1];
              sck_out <= !sync_mode;
            end
          end else begin
            tx_cnt <= tx_cnt - 16'h0001;
          end
        end
        TX_STOP: begin
          if (tx_cnt == 16'h0000) begin
            tx_cnt <= div - 16'h0001;
            tx_extra_stop <= 1'b0;
            if (!tx_extra_stop) begin
              tx_state <= TX_IDLE;
            end
          end else begin
            tx_cnt <= tx_cnt - 16'h0001;
          end
        end
        default: tx_state <= TX_IDLE;
      endcase
    end
  end

endmodule : srxef_top

/* File: srxef_pkg.sv */
// Constants and types shared by the serial receive error flag block.
// Assumes a single 200 MHz clock and a byte-addressed AXI4-Lite port.
package srxef_pkg;

  // Clock and default line rate
  localparam int CLK_HZ = 32'h0BEB_C200;
  localparam int BAUD_RATE = 32'h0001_C200;
  localparam logic [15:0] DIV_RESET = 16'(CLK_HZ / BAUD_RATE);

  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_DIV = 8'h04;
  localparam logic [7:0] ADDR_STAT = 8'h08;
  localparam logic [7:0] ADDR_RXDATA = 8'h0C;
  localparam logic [7:0] ADDR_TXDATA = 8'h10;

  // Control register fields
  localparam int CTRL_RX_ENABLE = 0;
  localparam int CTRL_TX_ENABLE = 1;
  localparam int CTRL_SYNC_MODE = 2;
  localparam int CTRL_TWO_STOP = 3;
  localparam int CTRL_RX_IRQ_EN = 4;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // Status register fields; flag i sits at STAT_FLAG_LSB + i
  localparam int STAT_FLAG_LSB = 4;
  localparam int FLAG_FRAMING = 0;
  localparam int FLAG_OVERRUN = 1;
  localparam int FLAG_RX_FULL = 2;
  localparam int NUM_FLAGS = 3;
  localparam int STAT_TX_SPACE = 7;
  localparam logic [2:0] FLAGS_RESET = 3'h0;

  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Character and transmit buffer
  localparam int CHAR_W = 8;
  localparam int TX_FIFO_DEPTH = 16;
  localparam logic [2:0] LAST_BIT = 3'h7;

  typedef enum logic [2:0] {
    RX_IDLE = 3'h0,
    RX_START = 3'h1,
    RX_DATA = 3'h2,
    RX_STOP1 = 3'h3,
    RX_STOP2 = 3'h4
  } srxef_rx_state_t;

  typedef enum logic [1:0] {
    TX_IDLE = 2'h0,
    TX_START = 2'h1,
    TX_DATA = 2'h2,
    TX_STOP = 2'h3
  } srxef_tx_state_t;

endpackage : srxef_pkg

/* File: srxef_fifo.sv */
// Synchronous FIFO with valid/ready on both sides, registered read data.
// Assumes one clock; the drain side may stall for any time.
`timescale 1ns/1ps
module srxef_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [PW:0] count;
  logic push;
  logic pop;

  assign in_ready = (count != (PW+1)'(DEPTH));
  assign push = in_valid && in_ready;
  // Refill the output register whenever it is empty or being taken
  assign pop = (count != '0) && (!out_valid || out_ready);

  always_ff @(posedge aclk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + PW'(1);
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + PW'(1);
      end
      count <= count + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_valid <= 1'b0;
      out_data <= '0;
    end else if (pop) begin
      out_valid <= 1'b1;
      out_data <= mem[rd_ptr];
    end else if (out_ready) begin
      out_valid <= 1'b0;
    end
  end

endmodule : srxef_fifo

/* File: srxef_monitor.sv */
// Port-level bus and interrupt checks for the serial error flag block.
// Sees only the top ports; bound to srxef_top below.
`timescale 1ns/1ps
module srxef_monitor
  import srxef_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Write channels
  input wire logic awvalid,
  input wire logic awready,
  input wire logic [7:0] awaddr,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [31:0] wdata,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [1:0] bresp,
  // Read channels
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [7:0] araddr,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  // Interrupt
  input wire logic rx_err_irq
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic wr_both;
  logic [3:0] wr_age;
  assign wr_both = awvalid && awready && wvalid && wready;
  function automatic logic mapped(input logic [7:0] a);
    return a[1:0] == 2'h0 && a <= ADDR_TXDATA;
  endfunction : mapped
  // Age of the last status or control write; irq may only fall after one
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_age <= 4'hF;
    end else if (wr_both && (awaddr == ADDR_STAT || awaddr == ADDR_CTRL)) begin
      wr_age <= 4'h0;
    end else if (wr_age != 4'hF) begin
      wr_age <= wr_age + 4'h1;
    end
  end
  property p_b_hold;
    bvalid && !bready |=> bvalid && $stable(bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("bvalid dropped");
  property p_r_hold;
    rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data moved");
  property p_r_answer;
    arvalid && arready |=> rvalid;
  endproperty
  a_r_answer: assert property (p_r_answer) else $error("read late");
  property p_r_drop;
    rvalid && rready |=> !rvalid;
  endproperty
  a_r_drop: assert property (p_r_drop) else $error("rvalid held");
  property p_b_answer;
    wr_both && awaddr != ADDR_TXDATA |-> ##2 bvalid;
  endproperty
  a_b_answer: assert property (p_b_answer) else $error("write late");
  property p_r_err;
    arvalid && arready && !mapped(araddr) |=> rresp == RESP_SLVERR;
  endproperty
  a_r_err: assert property (p_r_err) else $error("read not refused");
  property p_b_err;
    wr_both && !mapped(awaddr) |-> ##2 bresp == RESP_SLVERR;
  endproperty
  a_b_err: assert property (p_b_err) else $error("write not refused");
  property p_irq_fall;
    $fell(rx_err_irq) |-> wr_age <= 4'h6;
  endproperty
  a_irq_fall: assert property (p_irq_fall)
    else $error("irq fell");
  property p_irq_keep;
    wr_both && awaddr == ADDR_CTRL && wdata[CTRL_RX_IRQ_EN] && rx_err_irq
      |=> rx_err_irq [*4];
  endproperty
  a_irq_keep: assert property (p_irq_keep)
    else $error("flag lost");
  c_irq: cover property (rx_err_irq ##1 !rx_err_irq);
  c_stat_wr: cover property (wr_both && awaddr == ADDR_STAT);
  c_err: cover property (rvalid && rresp == RESP_SLVERR);
endmodule : srxef_monitor

bind srxef_top srxef_monitor u_mon (.aclk, .aresetn, .awvalid, .awready,
  .awaddr, .wvalid, .wready, .wdata, .bvalid, .bready, .bresp, .arvalid,
  .arready, .araddr, .rvalid, .rready, .rdata, .rresp, .rx_err_irq);

/* File: srxef_line_model.sv */
// Remote asynchronous transmitter driving the receive line.
// Takes a request only while idle; stop bit values come from the bench.
`timescale 1ns/1ps
module srxef_line_model (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Frame request
  input wire logic req,
  input wire logic [7:0] data,
  input wire logic stop1,
  input wire logic stop2,
  input wire logic two_stop,
  input wire logic [15:0] bit_cycles,
  // Line
  output logic busy,
  output logic rxd
);
  logic [10:0] sh;
  logic [15:0] cnt;
  logic [3:0] nleft;
  // Line idles high; start low, data LSB first, then stop bits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy <= 1'b0;
      rxd <= 1'b1;
    end else if (!busy) begin
      if (req) begin
        sh <= {stop2, stop1, data, 1'b0};
        nleft <= two_stop ? 4'hB : 4'hA;
        cnt <= 16'h0000;
        busy <= 1'b1;
        rxd <= 1'b0;
      end
    end else if (cnt != bit_cycles - 16'h0001) begin
      cnt <= cnt + 16'h0001;
    end else begin
      cnt <= 16'h0000;
      if (nleft == 4'h1) begin
        busy <= 1'b0;
        rxd <= 1'b1;
      end else begin
        rxd <= sh[1];
        sh <= sh >> 1;
        nleft <= nleft - 4'h1;
      end
    end
  end
endmodule : srxef_line_model

/* File: srxef_top_tb.sv */
// Self-checking bench for the serial error flag block.
// Drives AXI4-Lite and a line transmitter model on one 200 MHz clock.
`timescale 1ns/1ps
module srxef_top_tb
  import srxef_pkg::*;
;
  logic aclk = 0;
  logic aresetn = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [7:0] awaddr = 0, araddr = 0, ldata = 0;
  logic [31:0] wdata = 0, rdata, v;
  logic awready, wready, bvalid, arready, rvalid, txd, sck_out, rx_err_irq;
  logic [1:0] bresp, rresp, r;
  logic rxd, lbusy, lreq = 0, lstop1 = 1, lstop2 = 1, ltwo = 0;
  logic [7:0] b[6];
  int miscompares = 0, n_compared = 0, n, k, tl;
  srxef_top u_dut (.aclk, .aresetn, .awvalid, .awready, .awaddr, .wvalid,
    .wready, .wdata, .wstrb(4'hF), .bvalid, .bready, .bresp, .arvalid,
    .arready, .araddr, .rvalid, .rready, .rdata, .rresp, .rxd, .txd,
    .sck_out, .rx_err_irq);
  srxef_line_model u_line (.aclk, .aresetn, .req(lreq), .data(ldata),
    .stop1(lstop1), .stop2(lstop2), .two_stop(ltwo),
    .bit_cycles(16'h0008), .busy(lbusy), .rxd);
  function automatic logic [31:0] se(input logic f, o, u);
    se = 32'h0;
    se[STAT_FLAG_LSB + FLAG_FRAMING] = f;
    se[STAT_FLAG_LSB + FLAG_OVERRUN] = o;
    se[STAT_FLAG_LSB + FLAG_RX_FULL] = u;
  endfunction : se
  task automatic give_verdict();
    $display("compared %0d, miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : give_verdict
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // Every wait is bounded; running out counts as a mismatch
  task automatic limit(inout int c);
    c++;
    if (c > 3000) begin
      miscompares++;
      give_verdict();
    end
  endtask : limit
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw;
    ta = 0;
    tw = 0;
    n = 0;
    awvalid <= 1;
    awaddr <= a;
    wvalid <= 1;
    wdata <= d;
    while (!(ta && tw)) begin
      @(posedge aclk);
      limit(n);
      if (awready === 1'b1) begin
        ta = 1;
        awvalid <= 0;
      end
      if (wready === 1'b1) begin
        tw = 1;
        wvalid <= 0;
      end
    end
    bready <= 1;
    do begin
      @(posedge aclk);
      limit(n);
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    n = 0;
    arvalid <= 1;
    araddr <= a;
    do begin
      @(posedge aclk);
      limit(n);
    end while (arready !== 1'b1);
    arvalid <= 0;
    rready <= 1;
    do begin
      @(posedge aclk);
      limit(n);
    end while (rvalid !== 1'b1);
    v = rdata;
    r = rresp;
    rready <= 0;
  endtask : rd
  task automatic st(input logic [31:0] exp);
    rd(ADDR_STAT);
    check(v & 32'h0000_0070, exp);
  endtask : st
  task automatic send(input logic [7:0] d, input logic s1, input logic s2);
    n = 0;
    lreq <= 1;
    ldata <= d;
    lstop1 <= s1;
    lstop2 <= s2;
    @(posedge aclk);
    lreq <= 0;
    do begin
      @(posedge aclk);
      limit(n);
    end while (lbusy !== 1'b0);
  endtask : send
  task automatic sck_lows();
    k = 0;
    tl = 0;
    repeat (64) begin
      @(posedge aclk);
      if (sck_out !== 1'b1) k++;
      if (txd !== 1'b1) tl++;
    end
  endtask : sck_lows
  initial begin
    forever #2.5 aclk = ~aclk;
  end
  initial begin
    v = $urandom(39);
    foreach (b[i]) b[i] = 8'($urandom());
    repeat (8) @(posedge aclk);
    aresetn <= 1;
    rd(ADDR_CTRL);
    check(v, 32'(CTRL_RESET));
    rd(ADDR_DIV);
    check(v, 32'(DIV_RESET));
    st(se(0, 0, 0));
    rd(8'h20);
    check(32'(r), 32'(RESP_SLVERR));
    wr(8'h20, 32'h0000_0000);
    check(32'(r), 32'(RESP_SLVERR));
    wr(ADDR_DIV, 32'h0000_0008);
    wr(ADDR_CTRL, 32'h0000_0011);
    send(b[0], 1, 1);
    st(se(0, 0, 1));
    wr(ADDR_STAT, 32'hFFFF_FFFF);
    send(b[1], 1, 1);
    wr(ADDR_STAT, 32'h0000_0000);
    st(se(0, 1, 1));
    rd(ADDR_RXDATA);
    check(v, 32'(b[0]));
    check(32'(rx_err_irq), 32'h1);
    // Empty the data register so a forbidden reception would show
    wr(ADDR_STAT, se(0, 1, 0));
    send(b[2], 1, 0);
    rd(ADDR_RXDATA);
    check(v, 32'(b[0]));
    wr(ADDR_CTRL, 32'h0000_0010);
    st(se(0, 1, 0));
    wr(ADDR_STAT, se(0, 0, 1));
    st(se(0, 0, 0));
    check(32'(rx_err_irq), 32'h0);
    wr(ADDR_STAT, 32'h0000_0000);
    ltwo <= 1;
    wr(ADDR_CTRL, 32'h0000_0019);
    send(b[3], 1, 0);
    st(se(0, 0, 1));
    // Low second stop looks like a start; abort it by dropping enable
    wr(ADDR_CTRL, 32'h0000_0010);
    rd(ADDR_RXDATA);
    check(v, 32'(b[3]));
    wr(ADDR_STAT, 32'h0000_0000);
    ltwo <= 0;
    wr(ADDR_CTRL, 32'h0000_0011);
    send(b[4], 0, 1);
    st(se(1, 0, 0));
    rd(ADDR_RXDATA);
    check(v, 32'(b[4]));
    check(32'(rx_err_irq), 32'h1);
    send(b[5], 1, 1);
    rd(ADDR_RXDATA);
    check(v, 32'(b[4]));
    wr(ADDR_CTRL, 32'h0000_0010);
    st(se(1, 0, 0));
    // Fill the transmit buffer while the framing flag holds it back
    wr(ADDR_CTRL, 32'h0000_0006);
    repeat (17) wr(ADDR_TXDATA, 32'(b[0]));
    rd(ADDR_STAT);
    check(32'(v[STAT_TX_SPACE]), 32'h0);
    sck_lows();
    check(32'(k), 32'h0);
    check(32'(tl), 32'h0);
    st(se(1, 0, 0));
    wr(ADDR_STAT, 32'h0000_0000);
    st(se(0, 0, 0));
    sck_lows();
    check(32'(k > 0), 32'h1);
    check(32'(tl > 0), 32'(b[0] != 8'hFF));
    k = 0;
    do begin
      rd(ADDR_STAT);
      limit(k);
    end while (v[STAT_TX_SPACE] !== 1'b1);
    // Receive alongside transmit; the second completion overruns
    wr(ADDR_CTRL, 32'h0000_0007);
    k = 0;
    do begin
      rd(ADDR_STAT);
      limit(k);
    end while (v[STAT_FLAG_LSB + FLAG_OVERRUN] !== 1'b1);
    sck_lows();
    check(32'(k), 32'h0);
    st(se(0, 1, 1));
    rd(ADDR_RXDATA);
    check(v, 32'h0000_00FF);
    give_verdict();
  end
endmodule : srxef_top_tb
